//--- core/apd_pkg.sv
/*
  Shared constants for the auxiliary port direction block: register
  offsets, field positions, reset values and widths.
  Assumes the importing module uses an 8-bit data and 4-bit address port.
*/
package apd_pkg;
  // Port geometry
  localparam int unsigned APD_NBITS = 6; // Pins in the auxiliary port
  localparam int unsigned APD_NSHARE = 3; // Pins in each shared half
  localparam int unsigned APD_DW = 8; // Register data width
  localparam int unsigned APD_AW = 4; // Register address width
  localparam int unsigned APD_MAIN_HI = 5; // Main inputs beyond the shared

  // Register offsets
  localparam logic [3:0] APD_OFS_DIR = 4'h0; // port_c_direction
  localparam logic [3:0] APD_OFS_LVL = 4'h1; // Output level latch
  localparam logic [3:0] APD_OFS_PINS = 4'h2; // Aux pin levels
  localparam logic [3:0] APD_OFS_BITOP = 4'h3; // Set-high / set-low
  localparam logic [3:0] APD_OFS_MAIN = 4'h4; // Main input levels
  localparam logic [3:0] APD_OFS_CMASK = 4'h5; // Condition mask
  localparam logic [3:0] APD_OFS_CVAL = 4'h6; // Condition value
  localparam logic [3:0] APD_OFS_CCTL = 4'h7; // Condition select/result

  // Reset values
  localparam logic [5:0] APD_DIR_RST = 6'h07; // Bits 0..2 out, 3..5 in
  localparam logic [5:0] APD_LVL_RST = 6'h00; // All levels low
  localparam logic [7:0] APD_ZERO8 = 8'h00; // Empty byte

  // Fields of the bit operation word
  localparam int unsigned APD_BITOP_IDX_LSB = 0; // Bit index, 3 bits
  localparam int unsigned APD_BITOP_LVL = 3; // 1 = set high, 0 = low
  localparam logic [2:0] APD_IDX_LAST = 3'h5; // Highest legal index

  // Fields of the condition control register
  localparam int unsigned APD_CCTL_SEL = 0; // 1 = aux port, 0 = main
  localparam int unsigned APD_CCTL_HIT = 1; // Result, read only
endpackage : apd_pkg

//--- core/apd_sync.sv
/*
  Two flip-flop synchroniser for a bus of asynchronous levels.
  Assumes an active-low reset already synchronous to clk_sys.
*/
`timescale 1ns/1ps
module apd_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q; // First stage, read only by second stage

  // Two stages; the first is never looked at by other logic
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // apd_sync

//--- core/apd_top.sv
/*
  Six-bit auxiliary general-purpose port with per-bit direction, output
  levels, bit set-high/set-low operations, plain input reads and a
  single-port condition test, reached over a simple register port.
  Assumes pins are sampled from outside the clock domain, that the fixed
  output functions (serial, pulse) arrive on clk_sys, and a 250 MHz clock.
*/
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
module apd_top
  import apd_pkg::*;
#(
  parameter int unsigned NBITS = APD_NBITS
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [APD_AW-1:0] reg_addr,
  input wire logic [APD_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [APD_DW-1:0] reg_rdata,
  input wire logic [NBITS-1:0] pin_in,
  output logic [NBITS-1:0] pin_out,
  output logic [NBITS-1:0] pin_oe,
  input wire logic [APD_MAIN_HI-1:0] main_in_pin,
  input wire logic [APD_NSHARE-1:0] func_en,
  input wire logic [APD_NSHARE-1:0] func_val
);

  // Reset synchroniser stages
  logic rst_meta_q; // First stage, only feeds the second
  logic rst_n_s; // Released reset used by the whole block

  // Synchronised pin levels
  logic [NBITS-1:0] pin_lvl; // Aux pins after two flops
  logic [APD_MAIN_HI-1:0] main_hi_lvl; // Main inputs 3..7 after two flops

  // Software-visible state
  logic [NBITS-1:0] dir_q; // Direction, 1 = output
  logic [NBITS-1:0] dir_d; // Next direction
  logic [NBITS-1:0] lvl_q; // Output level latch
  logic [NBITS-1:0] lvl_d; // Next output level
  logic [APD_DW-1:0] cmask_q; // Condition mask
  logic [APD_DW-1:0] cval_q; // Condition compare value
  logic csel_q; // Condition port select
  logic chit_q; // Condition result

  // Pin drive registers
  logic [NBITS-1:0] pin_out_q; // Registered pin level
  logic [NBITS-1:0] pin_oe_q; // Registered output enable
  logic [NBITS-1:0] drv_d; // Next pin level

  // Read data register
  logic [APD_DW-1:0] rdata_q; // Answer, valid one cycle after read
  logic [APD_DW-1:0] rdata_d; // Selected read value

  // Decoded strobes and condition words
  logic wr_dir; // Write to direction register
  logic wr_lvl; // Write to level latch
  logic wr_bitop; // Bit operation request
  logic [2:0] op_idx; // Index carried by the bit operation
  logic op_lvl; // Level carried by the bit operation
  logic op_ok; // Index names a real pin
  logic [APD_DW-1:0] main_word; // Main input port as a byte
  logic [APD_DW-1:0] aux_word; // Aux port as a byte
  logic [APD_DW-1:0] test_word; // The one port under test

  // Reset release through two flops; not gated by ce so reset can end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_s <= rst_meta_q;
    end
  end

  // Aux pins come from the outside world
  apd_sync #(
    .W(NBITS)
  ) u_sync_aux (
    .clk_sys(clk_sys),
    .rst_n(rst_n_s),
    .ce(ce),
    .d(pin_in),
    .q(pin_lvl)
  );

  // Remaining main inputs also come from pins
  apd_sync #(
    .W(APD_MAIN_HI)
  ) u_sync_main (
    .clk_sys(clk_sys),
    .rst_n(rst_n_s),
    .ce(ce),
    .d(main_in_pin),
    .q(main_hi_lvl)
  );

  // Address decode for writes
  assign wr_dir = reg_wr && (reg_addr == APD_OFS_DIR);
  assign wr_lvl = reg_wr && (reg_addr == APD_OFS_LVL);
  assign wr_bitop = reg_wr && (reg_addr == APD_OFS_BITOP);
  assign op_idx = reg_wdata[APD_BITOP_IDX_LSB +: 3];
  assign op_lvl = reg_wdata[APD_BITOP_LVL];
  // Indexes 6 and 7 name no pin and are dropped
  assign op_ok = (op_idx <= APD_IDX_LAST);

  // Next direction and level
  always_comb begin
    dir_d = dir_q;
    lvl_d = lvl_q;
    if (wr_dir) begin
      // Upper two bits are simply not stored
      dir_d = reg_wdata[NBITS-1:0];
    end else if (wr_lvl) begin
      lvl_d = reg_wdata[NBITS-1:0];
    end else if (wr_bitop && op_ok) begin
      // Direction and level change together, in one write
      dir_d[op_idx] = 1'b1;
      lvl_d[op_idx] = op_lvl;
    end
  end

  // Direction register, outputs on the low half after reset
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      dir_q <= APD_DIR_RST;
    end else if (ce) begin
      dir_q <= dir_d;
    end
  end

  // Output level latch
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      lvl_q <= APD_LVL_RST;
    end else if (ce) begin
      lvl_q <= lvl_d;
    end
  end

  // Condition registers
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      cmask_q <= APD_ZERO8;
      cval_q <= APD_ZERO8;
      csel_q <= 1'b0;
    end else if (ce) begin
      if (reg_wr && (reg_addr == APD_OFS_CMASK)) begin
        cmask_q <= reg_wdata;
      end
      if (reg_wr && (reg_addr == APD_OFS_CVAL)) begin
        cval_q <= reg_wdata;
      end
      if (reg_wr && (reg_addr == APD_OFS_CCTL)) begin
        csel_q <= reg_wdata[APD_CCTL_SEL];
      end
    end
  end

  // Main input port: its low three inputs are the aux high pins
  assign main_word = {main_hi_lvl, pin_lvl[NBITS-1:APD_NSHARE]};
  assign aux_word = {{(APD_DW-NBITS){1'b0}}, pin_lvl};
  // Only one port ever feeds the comparison; no mixing possible
  assign test_word = csel_q ? aux_word : main_word;

  // Condition result, re-evaluated every cycle that ce is high
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      chit_q <= 1'b0;
    end else if (ce) begin
      chit_q <= ((test_word & cmask_q) == (cval_q & cmask_q));
    end
  end

  // Pin drive selection per bit
  always_comb begin
    drv_d = lvl_q;
    for (int i = 0; i < APD_NSHARE; i++) begin
      // Low half doubles as fixed outputs, so those functions win
      if (func_en[i]) begin
        drv_d[i] = func_val[i];
      end
    end
    // High half never sees func_en: static latch levels only
  end

  // Registered pin drive; an input pin is released and held low
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pin_out_q <= APD_LVL_RST;
      pin_oe_q <= APD_DIR_RST;
    end else if (ce) begin
      pin_out_q <= drv_d & dir_q;
      pin_oe_q <= dir_q;
    end
  end

  // Read mux; unmapped offsets answer zero
  always_comb begin
    rdata_d = APD_ZERO8;
    unique case (reg_addr)
      APD_OFS_DIR: rdata_d = {2'b00, dir_q};
      APD_OFS_LVL: rdata_d = {2'b00, lvl_q};
      // Plain sampled levels; no counting or timing taps exist
      APD_OFS_PINS: rdata_d = aux_word;
      APD_OFS_MAIN: rdata_d = main_word;
      APD_OFS_CMASK: rdata_d = cmask_q;
      APD_OFS_CVAL: rdata_d = cval_q;
      APD_OFS_CCTL: rdata_d = {6'h00, chit_q, csel_q};
      default: rdata_d = APD_ZERO8; // Bit op and holes read zero
    endcase
  end

  // Read data stands after the strobe until the next edge with ce high, then clears
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      rdata_q <= APD_ZERO8;
    end else if (ce) begin
      rdata_q <= reg_rd ? rdata_d : APD_ZERO8;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = rdata_q;
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;

  // Checks, all on clk_sys under the released reset
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n_s);

  // Power-up directions must be visible in the first cycle after release
  property p_rst_dir;
    (rst_n_s && !$past(rst_n_s)) |-> (dir_q == APD_DIR_RST);
  endproperty
  a_rst_dir: assert property (p_rst_dir)
    else $error("direction not at reset value after release");

  property p_dir_to_oe;
    (wr_dir && ce) ##1 ce |=> (pin_oe == $past(reg_wdata[5:0], 2));
  endproperty
  a_dir_to_oe: assert property (p_dir_to_oe)
    else $error("pin enables do not follow direction write");

  property p_all_out;
    (wr_dir && ce && (reg_wdata[5:0] == 6'h3f)) ##1 ce |=> (&pin_oe);
  endproperty
  a_all_out: assert property (p_all_out)
    else $error("all-ones direction did not make all outputs");

  property p_all_in;
    (wr_dir && ce && (reg_wdata[5:0] == 6'h00)) ##1 ce |=> (pin_oe == 6'h00);
  endproperty
  a_all_in: assert property (p_all_in)
    else $error("zero direction did not make all inputs");

  property p_set_high;
    logic [2:0] k;
    // A fixed function owns bits 0..2 in the cycle the pin is loaded
    (wr_bitop && op_ok && op_lvl && ce, k = op_idx)
      ##1 (ce && ((k > 3'h2) || !func_en[k[1:0]]))
      |=> (pin_oe[k] && pin_out[k]);
  endproperty
  a_set_high: assert property (p_set_high)
    else $error("set-high did not drive the pin high as output");

  property p_set_low;
    logic [2:0] k;
    // Same load cycle as set-high; the function enable is seen there
    (wr_bitop && op_ok && !op_lvl && ce, k = op_idx)
      ##1 (ce && ((k > 3'h2) || !func_en[k[1:0]]))
      |=> (pin_oe[k] && !pin_out[k]);
  endproperty
  a_set_low: assert property (p_set_low)
    else $error("set-low did not drive the pin low as output");

  property p_func_low;
    (ce && dir_q[0] && func_en[0]) |=> (pin_out[0] == $past(func_val[0]));
  endproperty
  a_func_low: assert property (p_func_low)
    else $error("fixed output function not on shared low pin");

  // High half must never follow the fixed output functions
  property p_static_high;
    ce |=> (pin_out[5:3] == ($past(dir_q[5:3]) & $past(lvl_q[5:3])));
  endproperty
  a_static_high: assert property (p_static_high)
    else $error("high pins not driven from the static latch");

  property p_main_share;
    (reg_rd && ce && (reg_addr == APD_OFS_MAIN))
      |=> (reg_rdata[2:0] == $past(pin_lvl[5:3]));
  endproperty
  a_main_share: assert property (p_main_share)
    else $error("main inputs 0-2 are not aux pins 3-5");

  property p_pins_read;
    (reg_rd && ce && (reg_addr == APD_OFS_PINS))
      |=> (reg_rdata == {2'b00, $past(pin_lvl)});
  endproperty
  a_pins_read: assert property (p_pins_read)
    else $error("aux pin read is not the plain level");

  property p_dir_read;
    (reg_rd && ce && (reg_addr == APD_OFS_DIR))
      |=> (reg_rdata[7:6] == 2'b00);
  endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("direction bits 6-7 read nonzero");

  // Result rebuilt from raw levels, so a broken port mux is caught
  property p_one_port;
    ce |=> (chit_q == ($past(csel_q)
      ? ((({2'b00, $past(pin_lvl)} ^ $past(cval_q)) & $past(cmask_q))
        == 8'h00)
      : ((({$past(main_hi_lvl), $past(pin_lvl[5:3])} ^ $past(cval_q))
        & $past(cmask_q)) == 8'h00)));
  endproperty
  a_one_port: assert property (p_one_port)
    else $error("condition result not from one selected port");

  c_set_high: cover property (wr_bitop && op_ok && op_lvl && ce);
  c_all_out: cover property (wr_dir && (reg_wdata[5:0] == 6'h3f));
  c_hit_aux: cover property (csel_q && chit_q);
  c_func_drive: cover property (dir_q[1] && func_en[1] && ce);

endmodule // apd_top

//--- verif/apd_loads.sv
/*
  Switches and on/off loads hung on the six auxiliary pins.
  Assumes each switch ties its pin firmly to a rail; no pull resistors.
*/
`timescale 1ns/1ps
module apd_loads (
  input wire logic [5:0] pin_out, // Level the block drives
  input wire logic [5:0] pin_oe, // High where the block drives
  input wire logic [5:0] sw, // Switch positions from the bench
  output logic [5:0] pin_in // Wire level seen back by the block
);
  // Driven pins win; a released pin shows its switch, never the old drive
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & sw);
endmodule // apd_loads

//--- verif/tb_aux_port_direction_control.sv
/*
  Self-checking bench for the auxiliary port: register port tasks,
  random directions, levels and switches, bit operations and conditions.
  Assumes apd_top, apd_pkg and the apd_loads pin model are compiled first.
*/
`timescale 1ns/1ps
module tb_aux_port_direction_control;
  import apd_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [5:0] pin_in;
  logic [5:0] pin_out;
  logic [5:0] pin_oe;
  logic [5:0] sw = 6'h00; // Switch positions
  logic [4:0] main_in_pin = 5'h00;
  logic [2:0] func_en = 3'h0;
  logic [2:0] func_val = 3'h0;
  logic [5:0] m_dir; // Expected direction
  logic [5:0] m_lvl; // Expected level latch
  logic [5:0] e_pin; // Expected wire levels
  logic [7:0] rv; // Last read data
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;

  // 250 MHz system clock
  always #2 clk_sys = ~clk_sys;

  apd_top dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .main_in_pin(main_in_pin),
    .func_en(func_en), .func_val(func_val));

  apd_loads loads (.pin_out(pin_out), .pin_oe(pin_oe), .sw(sw),
    .pin_in(pin_in));

  // Drive level expected on the pins from the bench model
  function automatic logic [5:0] exp_out(input logic [5:0] d,
      input logic [5:0] l);
    logic [5:0] v;
    v = l;
    for (int i = 0; i < 3; i++) begin
      if (func_en[i]) begin
        v[i] = func_val[i];
      end
    end
    return v & d;
  endfunction

  task automatic print_verdict();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Data is taken in the one cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Enough edges for the pin registers and the input synchroniser
  task automatic settle();
    repeat (5) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk_pins();
    chk("pin_oe", {2'b00, pin_oe}, {2'b00, m_dir});
    chk("pin_out", {2'b00, pin_out}, {2'b00, exp_out(m_dir, m_lvl)});
  endtask

  // Hang guard, far above the expected run length
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    void'($urandom(14641));
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    m_dir = APD_DIR_RST;
    m_lvl = APD_LVL_RST;
    #1 chk_pins();
    rd(APD_OFS_DIR, rv);
    chk("dir reset", rv, 8'h07);
    // All outputs, high bits dropped, then all inputs
    wr(APD_OFS_DIR, 8'hFF);
    m_dir = 6'h3F;
    settle();
    chk_pins();
    rd(APD_OFS_DIR, rv);
    chk("dir all", rv, 8'h3F);
    wr(APD_OFS_DIR, 8'h00);
    m_dir = 6'h00;
    settle();
    chk_pins();
    // Every index and level from an input with the opposite latch
    for (int i = 0; i < 16; i++) begin
      wr(APD_OFS_DIR, 8'h00);
      wr(APD_OFS_LVL, {8{~i[0]}});
      m_dir = 6'h00;
      m_lvl = {6{~i[0]}};
      wr(APD_OFS_BITOP, {4'h0, i[0], i[3:1]});
      if (i < 12) begin
        m_dir[i / 2] = 1'b1;
        m_lvl[i / 2] = i[0];
      end
      settle();
      chk_pins();
    end
    // Random directions, levels, switches and fixed functions
    repeat (24) begin
      rv = 8'($urandom);
      m_dir = rv[5:0];
      wr(APD_OFS_DIR, rv);
      rv = 8'($urandom);
      m_lvl = rv[5:0];
      wr(APD_OFS_LVL, rv);
      sw <= 6'($urandom);
      main_in_pin <= 5'($urandom);
      func_en <= 3'($urandom);
      func_val <= 3'($urandom);
      settle();
      chk_pins();
      e_pin = (m_dir & exp_out(m_dir, m_lvl)) | (~m_dir & sw);
      rd(APD_OFS_DIR, rv);
      chk("dir", rv, {2'b00, m_dir});
      rd(APD_OFS_PINS, rv);
      chk("pins", rv, {2'b00, e_pin});
      rd(APD_OFS_MAIN, rv);
      chk("main", rv, {main_in_pin, e_pin[5:3]});
    end
    // Condition on one port: aux bit 0 high, main bit 0 low
    @(posedge clk_sys);
    func_en <= 3'h0;
    wr(APD_OFS_DIR, 8'h00);
    sw <= 6'h01;
    wr(APD_OFS_CMASK, 8'h01);
    wr(APD_OFS_CVAL, 8'h01);
    wr(APD_OFS_CCTL, 8'h01);
    settle();
    rd(APD_OFS_CCTL, rv);
    chk("hit aux", {6'h00, rv[1:0]}, 8'h03);
    wr(APD_OFS_CCTL, 8'h00);
    settle();
    rd(APD_OFS_CCTL, rv);
    chk("hit main", {6'h00, rv[1:0]}, 8'h00);
    wr(APD_OFS_CMASK, 8'h00);
    settle();
    rd(APD_OFS_CCTL, rv);
    chk("hit none", {6'h00, rv[1:0]}, 8'h02);
    // Strobe lost while the clock enable is low
    m_dir = 6'h00;
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(APD_OFS_DIR, 8'h3F);
    ce <= 1'b1;
    settle();
    chk_pins();
    // Unmapped offsets read as zero
    for (int a = 8; a < 16; a++) begin
      rd(a[3:0], rv);
      chk("unmapped", rv, 8'h00);
    end
    // Second reset in mid-run restores the power-up directions
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    m_dir = APD_DIR_RST;
    m_lvl = APD_LVL_RST;
    #1 chk_pins();
    print_verdict();
  end
endmodule // tb_aux_port_direction_control
